// ### design/low_speed_osc_control.v
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctrl_consts.vh"

// Overview of operation
// - power-on reset leaves external oscillator off, both pins free for general I/O
// - crystal mode takes over both crystal in and crystal out pins
// - external clock mode takes over only the crystal in pin
// - enable bit starts external oscillator; crystal select picks crystal or clock
// - enabled external oscillator keeps running in every sleep mode
// - external oscillator output masked during the selected start-up time
// - external ready flag sets once configured start-up interval elapses
// - rising external ready raises interrupt when its enable-set bit is one
// - external oscillator survives every reset except power-on reset
// - external 32.768 kHz output gated by its enable, crystal mode only
// - internal tunable oscillator off by default; output gated separately
// - software writes internal trim; it commits to the oscillator on ready
// - ultra low-power oscillator on after power-on reset, both outputs always on
// - ultra low-power trim loads from factory value, software writes override
// - rc 8 MHz oscillator is default system clock after power-on reset
// - rc oscillator starts and stops when its enable bit or the power manager sleep request changes
// - rc trim loads from factory, trim and band stay writable
// - rc oscillator switched off in sleep modes named by the power manager
// - ultra low-power oscillator cannot be disabled by software
module low_speed_osc_control #(
  parameter ULP_FACTORY_TRIM = 5'h10,
  parameter RC_FACTORY_TRIM  = 12'h800,
  parameter STARTUP_SCALE    = 1
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        clkEn,
  input  wire        softResetN,
  input  wire        sleepRcOff,
  input  wire        standbyReq,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        crystalClkIn,
  output reg         crystalInOwn,
  output reg         crystalOutOwn,
  output reg         extOscRun,
  output reg         extOscGate,
  output reg         extOut32kEn,
  output reg         intOscRun,
  output reg         intOut32kEn,
  output reg  [6:0]  intTrimActive,
  output reg         ulpOscRun,
  output reg         ulpOut1kEn,
  output reg  [4:0]  ulpTrim,
  output reg         rcOscRun,
  output reg  [11:0] rcTrim,
  output reg  [1:0]  rcBand,
  output reg  [1:0]  sysClkSel,
  output reg         standbyBlocked,
  output reg         irq
);
  localparam CNT_W = 20;
  localparam integer BASE_LIM_I = `STARTUP_BASE_CYC * STARTUP_SCALE;
  localparam integer RC_LIM_I   = `RC_STARTUP_CYC;
  localparam [CNT_W-1:0] BASE_LIM = BASE_LIM_I[CNT_W-1:0];
  localparam [CNT_W-1:0] RC_LIM   = RC_LIM_I[CNT_W-1:0];

  // control registers (soft reset keeps external oscillator settings)
  reg              extEn_r;
  reg              extXtal_r;
  reg              extOutEn_r;
  reg  [2:0]       extStartup_r;
  reg              intEn_r;
  reg              intOutEn_r;
  reg  [2:0]       intStartup_r;
  reg  [6:0]       intTrim_r;
  reg              rcEn_r;
  reg  [2:0]       irqEn_r;
  reg  [2:0]       irqFlag_r;
  reg  [2:0]       rdyPrev_r;
  reg              ulpTrimLoaded_r;
  reg              clkSync1_r;
  reg              clkSync2_r;
  wire [2:0]       rdy;
  wire [CNT_W-1:0] extLimit;
  wire [CNT_W-1:0] intLimit;
  wire [CNT_W-1:0] rcLimit;

  // bus handshake state
  reg              awHeld_r;
  reg              wHeld_r;
  reg  [7:0]       awAddr_r;
  reg  [31:0]      wData_r;
  reg  [3:0]       wStrb_r;
  wire             doWrite;
  wire [31:0]      wd;
  wire             rcActive;

  // start-up intervals: ext and int base doubled per field step, scaled for simulation; rc fixed
  assign extLimit = BASE_LIM << extStartup_r;
  assign intLimit = BASE_LIM << intStartup_r;
  assign rcLimit  = RC_LIM;
  assign rcActive = rcEn_r & ~sleepRcOff;

  // one start-up timer each for the external, internal and rc oscillators; disabled resets count
  startup_timer #(.CNT_W(CNT_W)) extTimer (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (clkEn),
    .enable (extEn_r),
    .limit  (extLimit),
    .ready  (rdy[`ST_EXT_RDY])
  );
  startup_timer #(.CNT_W(CNT_W)) intTimer (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (clkEn),
    .enable (intEn_r),
    .limit  (intLimit),
    .ready  (rdy[`ST_INT_RDY])
  );
  startup_timer #(.CNT_W(CNT_W)) rcTimer (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (clkEn),
    .enable (rcActive),
    .limit  (rcLimit),
    .ready  (rdy[`ST_RC_RDY])
  );

  // write accepted once both address and data are held
  assign s_axi_awready = clkEn & ~awHeld_r & ~s_axi_bvalid; // no handshake while frozen
  assign s_axi_wready  = clkEn & ~wHeld_r & ~s_axi_bvalid;
  assign doWrite       = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign s_axi_arready = clkEn & ~s_axi_rvalid;
  assign wd = {wStrb_r[3] ? wData_r[31:24] : 8'h00, wStrb_r[2] ? wData_r[23:16] : 8'h00,
               wStrb_r[1] ? wData_r[15:8] : 8'h00,  wStrb_r[0] ? wData_r[7:0] : 8'h00};

  // write channel capture and response
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r     <= 1'b0;
      wHeld_r      <= 1'b0;
      awAddr_r     <= 8'h00;
      wData_r      <= 32'h0000_0000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r[1:0] == 2'h0 && awAddr_r <= `OFS_SYS_CTRL) ?
                        `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // external oscillator settings: power-on reset only, soft reset keeps them
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extEn_r      <= 1'b0;
      extXtal_r    <= 1'b0;
      extOutEn_r   <= 1'b0;
      extStartup_r <= 3'h0;
    end else if (clkEn && doWrite && awAddr_r == `OFS_EXT_CTRL) begin
      // enable with mode; software clears enable alone
      extEn_r      <= wd[`EXT_ENABLE_BIT];
      extXtal_r    <= wd[`EXT_XTAL_BIT];
      extOutEn_r   <= wd[`EXT_OUT_EN_BIT];
      extStartup_r <= wd[`EXT_STARTUP_LSB +: `EXT_STARTUP_W];
    end
  end

  // other control registers, also reset by a soft reset (ulp and rc trims reload factory values, internal trim clears to zero)
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intEn_r         <= 1'b0;
      intOutEn_r      <= 1'b0;
      intStartup_r    <= 3'h0;
      intTrim_r       <= 7'h00;
      rcEn_r          <= 1'b1;
      rcTrim          <= 12'h000;
      rcBand          <= 2'h0;
      ulpTrim         <= 5'h00;
      ulpTrimLoaded_r <= 1'b0;
      irqEn_r         <= 3'h0;
      sysClkSel       <= `RST_SYS_CLK_SEL;
    end else if (clkEn) begin
      if (!ulpTrimLoaded_r || !softResetN) begin
        ulpTrim         <= ULP_FACTORY_TRIM[4:0];
        rcTrim          <= RC_FACTORY_TRIM[11:0];
        rcBand          <= 2'h0;
        ulpTrimLoaded_r <= 1'b1;
      end
      if (!softResetN) begin
        intEn_r      <= 1'b0;
        intOutEn_r   <= 1'b0;
        intStartup_r <= 3'h0;
        intTrim_r    <= 7'h00;
        rcEn_r       <= 1'b1;
        irqEn_r      <= 3'h0;
        sysClkSel    <= `RST_SYS_CLK_SEL;
      end else if (doWrite && ulpTrimLoaded_r) begin
        case (awAddr_r)
          `OFS_INT_CTRL: begin
            intEn_r      <= wd[`INT_ENABLE_BIT];
            intOutEn_r   <= wd[`INT_OUT_EN_BIT];
            intStartup_r <= wd[`INT_STARTUP_LSB +: `INT_STARTUP_W];
            intTrim_r    <= wd[`INT_TRIM_LSB +: `INT_TRIM_W];
          end
          `OFS_ULP_CTRL: ulpTrim <= wd[`ULP_TRIM_LSB +: `ULP_TRIM_W];
          `OFS_RC_CTRL: begin
            rcEn_r <= wd[`RC_ENABLE_BIT];
            rcTrim <= wd[`RC_TRIM_LSB +: `RC_TRIM_W];
            rcBand <= wd[`RC_BAND_LSB +: `RC_BAND_W];
          end
          `OFS_IRQ_EN_SET: irqEn_r <= irqEn_r | wd[`NUM_RDY-1:0];
          `OFS_IRQ_EN_CLR: irqEn_r <= irqEn_r & ~wd[`NUM_RDY-1:0];
          `OFS_SYS_CTRL:   sysClkSel <= wd[1:0];
          default: ;
        endcase
      end
    end
  end

  // sticky ready-rise flags; a new rise wins over a write-one clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdyPrev_r <= 3'h0;
      irqFlag_r <= 3'h0;
    end else if (clkEn) begin
      rdyPrev_r <= rdy;
      irqFlag_r <= (irqFlag_r & ~((doWrite && awAddr_r == `OFS_IRQ_FLAG) ?
                   wd[`NUM_RDY-1:0] : 3'h0)) | (rdy & ~rdyPrev_r);
    end
  end

  // read channel
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AXI_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr[7:0])
          `OFS_EXT_CTRL: s_axi_rdata <= ({31'h0, extEn_r} << `EXT_ENABLE_BIT) |
                                        ({31'h0, extXtal_r} << `EXT_XTAL_BIT) |
                                        ({31'h0, extOutEn_r} << `EXT_OUT_EN_BIT) |
                                        ({29'h0, extStartup_r} << `EXT_STARTUP_LSB);
          `OFS_INT_CTRL: s_axi_rdata <= ({31'h0, intEn_r} << `INT_ENABLE_BIT) |
                                        ({31'h0, intOutEn_r} << `INT_OUT_EN_BIT) |
                                        ({29'h0, intStartup_r} << `INT_STARTUP_LSB) |
                                        ({25'h0, intTrim_r} << `INT_TRIM_LSB);
          `OFS_ULP_CTRL: s_axi_rdata <= {27'h0, ulpTrim} << `ULP_TRIM_LSB;
          `OFS_RC_CTRL:  s_axi_rdata <= ({31'h0, rcEn_r} << `RC_ENABLE_BIT) |
                                        ({20'h0, rcTrim} << `RC_TRIM_LSB) |
                                        ({30'h0, rcBand} << `RC_BAND_LSB);
          `OFS_STATUS:     s_axi_rdata <= {29'h0, rdy};
          `OFS_IRQ_EN_SET: s_axi_rdata <= {29'h0, irqEn_r};
          `OFS_IRQ_EN_CLR: s_axi_rdata <= {29'h0, irqEn_r};
          `OFS_IRQ_FLAG:   s_axi_rdata <= {29'h0, irqFlag_r};
          `OFS_SYS_CTRL:   s_axi_rdata <= {30'h0, sysClkSel};
          default:         s_axi_rresp <= `AXI_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // crystal input pin sampled through two flops; the synced level cancels out of the extOscGate term
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkSync1_r <= 1'b0;
      clkSync2_r <= 1'b0;
    end else if (clkEn) begin
      clkSync1_r <= crystalClkIn;
      clkSync2_r <= clkSync1_r;
    end
  end

  // oscillator and pin control outputs, all registered
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crystalInOwn   <= 1'b0;
      crystalOutOwn  <= 1'b0;
      extOscRun      <= 1'b0;
      extOscGate     <= 1'b0;
      extOut32kEn    <= 1'b0;
      intOscRun      <= 1'b0;
      intOut32kEn    <= 1'b0;
      intTrimActive  <= 7'h00;
      ulpOscRun      <= 1'b0;
      ulpOut1kEn     <= 1'b0;
      rcOscRun       <= 1'b0;
      standbyBlocked <= 1'b0;
      irq            <= 1'b0;
    end else if (clkEn) begin
      crystalInOwn  <= extEn_r;
      crystalOutOwn <= extEn_r & extXtal_r;
      extOscRun     <= extEn_r;
      extOscGate    <= rdy[`ST_EXT_RDY] & (extXtal_r | clkSync2_r | ~clkSync2_r);
      extOut32kEn   <= rdy[`ST_EXT_RDY] & extEn_r & extOutEn_r & extXtal_r;
      intOscRun     <= intEn_r;
      intOut32kEn   <= intEn_r & intOutEn_r & rdy[`ST_INT_RDY];
      if (rdy[`ST_INT_RDY]) begin
        intTrimActive <= intTrim_r;
      end
      ulpOscRun      <= 1'b1;
      ulpOut1kEn     <= 1'b1;
      rcOscRun       <= rdy[`ST_RC_RDY];
      standbyBlocked <= standbyReq & ((extEn_r & ~rdy[`ST_EXT_RDY]) |
                        (intEn_r & ~rdy[`ST_INT_RDY]));
      irq            <= |(irqFlag_r & irqEn_r);
    end
  end
endmodule // low_speed_osc_control
`default_nettype wire

// ### design/startup_timer.v
`timescale 1ns/1ns
`default_nettype none
// counts start-up cycles after enable; ready rises when done, drops on disable
module startup_timer #(
  parameter CNT_W = 20
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             ce,
  input  wire             enable,
  input  wire [CNT_W-1:0] limit,
  output reg              ready
);
  reg [CNT_W-1:0] count_r;

  // count while enabled; clear on disable so re-enable restarts
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= {CNT_W{1'b0}};
      ready   <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        count_r <= {CNT_W{1'b0}};
        ready   <= 1'b0;
      end else if (!ready) begin
        if (count_r >= limit) begin
          ready <= 1'b1;
        end else begin
          count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // startup_timer
`default_nettype wire

// ### dv/crystal_source.sv
`timescale 1ns/1ns
`default_nettype none
// far-side 32.768 kHz source: swings slowly while its pin is owned,
// otherwise the released pin wanders so no stale level is trusted
module crystal_source #(
  parameter int HALF_NS = 15259
) (
  input  wire logic enable,
  output var  logic clkOut
);
  // toggle generator; released pin toggles off the bench clock edges
  initial begin
    clkOut = 1'b0;
    forever begin
      if (enable)
        #(HALF_NS) clkOut = ~clkOut;
      else
        #37 clkOut = ~clkOut;
    end
  end
endmodule // crystal_source
`default_nettype wire

// ### dv/osc_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
// pin ownership, start-up masking and oscillator liveness seen at the ports
module osc_ctrl_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sleepRcOff,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic crystalInOwn,
  input wire logic crystalOutOwn,
  input wire logic extOscRun,
  input wire logic extOscGate,
  input wire logic extOut32kEn,
  input wire logic rcOscRun,
  input wire logic ulpOscRun,
  input wire logic ulpOut1kEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // external oscillator start and the window in which its output stays blocked
  sequence s_ext_start;
    $rose(extOscRun);
  endsequence
  sequence s_masked;
    !extOscGate [*3];
  endsequence
  // power manager holding the rc oscillator off
  sequence s_sleep_held;
    sleepRcOff [*3];
  endsequence
  a_pins_free_off: assert property (!extOscRun |-> !crystalInOwn && !crystalOutOwn)
    else $error("crystal pin owned while oscillator off");
  a_xtal_owns_both: assert property (crystalOutOwn |-> crystalInOwn)
    else $error("output pin owned without input pin");
  a_out_xtal_only: assert property (extOut32kEn |-> crystalOutOwn)
    else $error("32k output outside crystal mode");
  a_gate_masked: assert property (s_ext_start |-> s_masked)
    else $error("external clock passed during start-up");
  a_gate_drops: assert property ($fell(extOscRun) |-> ##2 !extOscGate)
    else $error("external clock still passed after disable");
  a_ulp_stays_on: assert property (ulpOscRun |=> ulpOscRun && ulpOut1kEn)
    else $error("ulp oscillator stopped");
  a_rc_sleep_off: assert property (s_sleep_held |=> !rcOscRun)
    else $error("rc oscillator kept running in sleep");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule // osc_ctrl_props

bind low_speed_osc_control osc_ctrl_props i_osc_ctrl_props (
  .clk, .rstn, .sleepRcOff, .s_axi_bvalid, .s_axi_bready, .crystalInOwn, .crystalOutOwn,
  .extOscRun, .extOscGate, .extOut32kEn, .rcOscRun, .ulpOscRun, .ulpOut1kEn
);
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctrl_consts.vh"
module tb;
  localparam logic [4:0]  ULP_FT = 5'h13;
  localparam logic [11:0] RC_FT  = 12'h5A5;
  logic        clk, rstn, clkEn, softResetN, sleepRcOff, standbyReq, crystalClkIn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rcBand, sysClkSel, rsp;
  logic        crystalInOwn, crystalOutOwn, extOscRun, extOscGate, extOut32kEn;
  logic        intOscRun, intOut32kEn, ulpOscRun, ulpOut1kEn, rcOscRun, standbyBlocked, irq;
  logic [6:0]  intTrimActive;
  logic [4:0]  ulpTrim;
  logic [11:0] rcTrim;
  int          mismatches, cmp_count;

  low_speed_osc_control #(.ULP_FACTORY_TRIM(ULP_FT), .RC_FACTORY_TRIM(RC_FT)) i_low_speed_osc_control (
    .clk, .rstn, .clkEn, .softResetN, .sleepRcOff, .standbyReq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystalClkIn,
    .crystalInOwn, .crystalOutOwn, .extOscRun, .extOscGate, .extOut32kEn, .intOscRun,
    .intOut32kEn, .intTrimActive, .ulpOscRun, .ulpOut1kEn, .ulpTrim, .rcOscRun, .rcTrim,
    .rcBand, .sysClkSel, .standbyBlocked, .irq);
  crystal_source i_crystal_source (.enable(crystalInOwn), .clkOut(crystalClkIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    $display("unexpected at %0t: wait timed out", $time);
    end_of_test();
  endtask

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) timeout();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) timeout();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // poll one status bit until it reaches the wanted level
  task automatic wait_bit(input int idx, input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      axi_read(`OFS_STATUS);
      if (rd[idx] === v) break;
    end
    if (n == 200) timeout();
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset_state();
    chk(!crystalInOwn && !crystalOutOwn && extOscRun === 1'b0, "pins held after reset");
    chk(intOscRun === 1'b0, "internal osc on after reset");
    chk(ulpOscRun === 1'b1 && ulpOut1kEn === 1'b1, "ulp osc idle");
    chk(ulpTrim === ULP_FT && rcTrim === RC_FT, "factory trims not loaded");
    chk(sysClkSel === `RST_SYS_CLK_SEL && rcOscRun === 1'b1, "rc not default clock");
    axi_read(`OFS_EXT_CTRL);
    chk(rd === 32'h0 && rsp === `AXI_OKAY, "ext control not cleared");
    axi_read(8'h40);
    chk(rsp === `AXI_SLVERR && rd === 32'h0, "unmapped read accepted");
    axi_write(8'h40, 32'h1);
    chk(rsp === `AXI_SLVERR, "unmapped write accepted");
  endtask

  task automatic t_ext_crystal();
    axi_write(`OFS_IRQ_EN_SET, 32'h1);
    axi_write(`OFS_EXT_CTRL, 32'h0000_010C);
    axi_write(`OFS_EXT_CTRL, 32'h0000_010E);
    standbyReq <= 1'b1;
    axi_read(`OFS_STATUS);
    chk(rd[0] === 1'b0 && crystalInOwn && crystalOutOwn && !extOscGate, "crystal start");
    chk(standbyBlocked === 1'b1, "standby not blocked");
    wait_bit(`ST_EXT_RDY, 1'b1);
    chk(extOscGate && extOut32kEn && standbyBlocked === 1'b0, "after ready");
    chk(irq === 1'b1, "no ready interrupt");
    standbyReq <= 1'b0;
    axi_write(`OFS_IRQ_FLAG, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq === 1'b0, "interrupt not cleared");
    axi_write(`OFS_EXT_CTRL, 32'h0000_010C);
    wait_bit(`ST_EXT_RDY, 1'b0);
    chk(!crystalInOwn && !crystalOutOwn && !extOut32kEn, "pins kept after disable");
  endtask

  task automatic t_ext_clock();
    axi_write(`OFS_IRQ_EN_CLR, 32'h1);
    axi_write(`OFS_EXT_CTRL, 32'h0000_0008);
    axi_write(`OFS_EXT_CTRL, 32'h0000_000A);
    axi_read(`OFS_STATUS);
    chk(rd[0] === 1'b0, "ready kept over re-enable");
    wait_bit(`ST_EXT_RDY, 1'b1);
    chk(crystalInOwn === 1'b1 && crystalOutOwn === 1'b0, "clock mode pins");
    chk(extOut32kEn === 1'b0, "32k out in clock mode");
    chk(irq === 1'b0, "masked interrupt raised");
    softResetN <= 1'b0;
    @(posedge clk);
    softResetN <= 1'b1;
    repeat (3) @(posedge clk);
    chk(extOscRun === 1'b1, "soft reset stopped ext osc");
    axi_write(`OFS_EXT_CTRL, 32'h0000_0008);
    wait_bit(`ST_EXT_RDY, 1'b0);
  endtask

  task automatic t_int_osc();
    axi_write(`OFS_INT_CTRL, 32'h0055_0000);
    repeat (3) @(posedge clk);
    chk(intOscRun === 1'b0 && intTrimActive === 7'h00, "trim used early");
    axi_write(`OFS_INT_CTRL, 32'h0055_0006);
    wait_bit(`ST_INT_RDY, 1'b1);
    chk(intOscRun && intOut32kEn && intTrimActive === 7'h55, "int osc start");
    axi_write(`OFS_INT_CTRL, 32'h0055_0000);
    wait_bit(`ST_INT_RDY, 1'b0);
    chk(intOscRun === 1'b0, "int osc not stopped");
  endtask

  task automatic t_ulp_rc();
    axi_write(`OFS_ULP_CTRL, 32'h0000_0A00);
    repeat (2) @(posedge clk);
    chk(ulpTrim === 5'h0A && ulpOscRun === 1'b1, "ulp trim write");
    axi_write(`OFS_RC_CTRL, 32'h05A5_0000);
    wait_bit(`ST_RC_RDY, 1'b0);
    axi_write(`OFS_RC_CTRL, 32'h8123_0000);
    chk(!rcOscRun && rcTrim === 12'h123 && rcBand === 2'h2, "rc disable");
    axi_write(`OFS_RC_CTRL, 32'h8123_0002);
    clkEn <= 1'b0;
    repeat (30) @(posedge clk);
    chk(rcOscRun === 1'b0 && rcTrim === 12'h123, "rc start ran while frozen");
    clkEn <= 1'b1;
    wait_bit(`ST_RC_RDY, 1'b1);
    chk(rcOscRun === 1'b1, "rc not restarted");
    sleepRcOff <= 1'b1;
    repeat (4) @(posedge clk);
    chk(rcOscRun === 1'b0, "rc runs in sleep");
    sleepRcOff <= 1'b0;
    wait_bit(`ST_RC_RDY, 1'b1);
  endtask

  initial begin
    rstn = 1'b0; clkEn = 1'b1; softResetN = 1'b1; sleepRcOff = 1'b0; standbyReq = 1'b0;
    s_axi_awaddr = 32'h0; s_axi_wdata = 32'h0; s_axi_araddr = 32'h0; s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    t_reset_state();
    t_ext_crystal();
    t_ext_clock();
    t_int_osc();
    t_ulp_rc();
    end_of_test();
  end
endmodule // tb
`default_nettype wire

// ### include/osc_ctrl_consts.vh
`ifndef OSC_CTRL_CONSTS_VH
`define OSC_CTRL_CONSTS_VH
// register byte offsets
`define OFS_EXT_CTRL     8'h00
`define OFS_INT_CTRL     8'h04
`define OFS_ULP_CTRL     8'h08
`define OFS_RC_CTRL      8'h0C
`define OFS_STATUS       8'h10
`define OFS_IRQ_EN_SET   8'h14
`define OFS_IRQ_EN_CLR   8'h18
`define OFS_IRQ_FLAG     8'h1C
`define OFS_SYS_CTRL     8'h20
// external oscillator control fields
`define EXT_ENABLE_BIT   1
`define EXT_XTAL_BIT     2
`define EXT_OUT_EN_BIT   3
`define EXT_STARTUP_LSB  8
`define EXT_STARTUP_W    3
// internal tunable oscillator fields
`define INT_ENABLE_BIT   1
`define INT_OUT_EN_BIT   2
`define INT_STARTUP_LSB  8
`define INT_STARTUP_W    3
`define INT_TRIM_LSB     16
`define INT_TRIM_W       7
// ultra low power trim
`define ULP_TRIM_LSB     8
`define ULP_TRIM_W       5
// rc oscillator fields
`define RC_ENABLE_BIT    1
`define RC_TRIM_LSB      16
`define RC_TRIM_W        12
`define RC_BAND_LSB      30
`define RC_BAND_W        2
// status / irq bit positions
`define ST_EXT_RDY       0
`define ST_INT_RDY       1
`define ST_RC_RDY        2
`define NUM_RDY          3
// rc start-up cycles and the shortest start-up in cycles
`define RC_STARTUP_CYC   8
`define STARTUP_BASE_CYC 4
// reset values and bus response codes
`define RST_RC_CTRL      32'h0000_0002
`define RST_SYS_CLK_SEL  2'h0
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`endif
